// File: design/tls_regs.svh
`ifndef TLS_REGS_SVH
`define TLS_REGS_SVH

// Register byte offsets
`define TLS_OFF_MODE 8'h00
`define TLS_OFF_METHOD 8'h04
`define TLS_OFF_LIM1 8'h08
`define TLS_OFF_LIM2 8'h0c
`define TLS_OFF_LIM3 8'h10
`define TLS_OFF_LIM4 8'h14
`define TLS_OFF_INFN_LO 8'h18
`define TLS_OFF_INFN_HI 8'h1c
`define TLS_OFF_OUTFN_LO 8'h20
`define TLS_OFF_OUTFN_HI 8'h24
`define TLS_OFF_OLR 8'h28
`define TLS_OFF_STATUS 8'h2c
`define TLS_OFF_IRQ_STAT 8'h30
`define TLS_OFF_IRQ_MASK 8'h34

// Reset values
`define TLS_RST_MODE 3'h0
`define TLS_RST_METHOD 3'h3
`define TLS_RST_LIM 8'hc8
`define TLS_RST_OLR_LEVEL 12'h800
`define TLS_RST_OLR_DECEL 9'h01e

// Codes and limits
`define TLS_FN_ENABLE 8'h28
`define TLS_FN_SEL_LSB 8'h29
`define TLS_FN_SEL_MSB 8'h2a
`define TLS_FN_IN_LIMIT 8'h0a
`define TLS_PCT_FULL 8'hc8
`define TLS_METH_SLV 3'h3
`define TLS_METH_SLV0 3'h4
`define TLS_METH_FB 3'h5
`define TLS_OLR_LVL_MIN 12'h200
`define TLS_OLR_LVL_MAX 12'h800
`define TLS_OLR_DEC_MIN 9'h001
`define TLS_OLR_DEC_MAX 9'h12c

// Scaling: analog 10 V = code 4000, current 4094 = 200 % of max
`define TLS_ANA_GAIN 14'h3334
`define TLS_ANA_SHIFT 18
`define TLS_CUR_GAIN 15'h51e6
`define TLS_CUR_SHIFT 10
`define TLS_CUR_MAX 12'hfff

// Interrupt bits
`define TLS_IRQ_LIM_ON 0
`define TLS_IRQ_LIM_OFF 1
`define TLS_IRQ_SRC_BAD 2

`endif

// File: design/tls_pkg.sv
package tls_pkg;

    typedef enum logic [2:0] {
        TLS_MODE_QUAD = 3'b000,
        TLS_MODE_TERM = 3'b001,
        TLS_MODE_ANALOG = 3'b010,
        TLS_MODE_CARD1 = 3'b011,
        TLS_MODE_CARD2 = 3'b100
    } tls_mode_t;

    typedef enum logic [1:0] {
        TLS_BUS_IDLE = 2'b00,
        TLS_BUS_WR = 2'b01,
        TLS_BUS_RD = 2'b10,
        TLS_BUS_RDOUT = 2'b11
    } tls_bus_st_t;

    // Motor loop side: quadrant and torque demand, current
    typedef struct packed {
        logic reverse;
        logic regen;
        logic [8:0] demand_pct;
        logic [11:0] current;
    } tls_motor_t;

    // One expansion card source
    typedef struct packed {
        logic fitted;
        logic [7:0] limit_pct;
    } tls_card_t;

    // Applied limit toward the control loop
    typedef struct packed {
        logic [7:0] limit_pct;
        logic [11:0] cur_limit;
        logic in_limit;
        logic olr_active;
        logic [8:0] olr_decel;
    } tls_limit_t;

    typedef struct packed {
        tls_bus_st_t bus_st;
        logic a_write;
        logic [7:0] a_addr;
        logic [31:0] hrdata;
        logic [2:0] mode;
        logic [2:0] method;
        logic [3:0][7:0] lim;
        logic [7:0][7:0] in_func;
        logic [4:0][7:0] out_func;
        logic olr_en;
        logic [11:0] olr_level;
        logic [8:0] olr_decel;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic irq;
        logic lim_active;
        logic src_bad;
        logic [7:0] limit_pct;
        logic [11:0] cur_limit;
        logic in_limit;
        logic olr_active;
        logic [4:0] out_pins;
    } tls_state_t;

endpackage

// File: design/tls_term_fn.sv
`timescale 1ns/1ps
`include "tls_regs.svh"

// Decodes the function assigned to one intelligent input terminal
module tls_term_fn
    import tls_pkg::*;
(
    input wire logic [7:0] func,
    input wire logic pin,
    output logic en_asg,
    output logic en_on,
    output logic lsb_on,
    output logic msb_on
);
    // Function match per terminal
    always_comb begin
        en_asg = (func == `TLS_FN_ENABLE);
        en_on = en_asg & pin;
        lsb_on = (func == `TLS_FN_SEL_LSB) & pin;
        msb_on = (func == `TLS_FN_SEL_MSB) & pin;
    end
endmodule // tls_term_fn

// File: design/tls_lim_scale.sv
`timescale 1ns/1ps
`include "tls_regs.svh"

// Analog code to percent, and percent to current code
module tls_lim_scale
    import tls_pkg::*;
(
    input wire logic [11:0] ana_code,
    input wire logic [7:0] pct,
    output logic [7:0] ana_pct,
    output logic [11:0] cur_code
);
    logic [25:0] ana_prod;
    logic [22:0] cur_prod;
    logic [12:0] cur_full;

    // Linear maps with saturation at full scale
    always_comb begin
        ana_prod = 26'(ana_code) * 26'(`TLS_ANA_GAIN);
        if (ana_prod[25:`TLS_ANA_SHIFT] > `TLS_PCT_FULL) begin
            ana_pct = `TLS_PCT_FULL;
        end else begin
            ana_pct = ana_prod[25:`TLS_ANA_SHIFT];
        end
        cur_prod = 23'(pct) * 23'(`TLS_CUR_GAIN);
        cur_full = cur_prod[22:`TLS_CUR_SHIFT];
        if (cur_full > {1'b0, `TLS_CUR_MAX}) begin
            cur_code = `TLS_CUR_MAX;
        end else begin
            cur_code = cur_full[11:0];
        end
    end
endmodule // tls_lim_scale

// File: design/tls_top.sv
`timescale 1ns/1ps
`include "tls_regs.svh"

// Contract
// - The mode setting picks the source: 0 quadrant, 1 terminals, 2 analog, 3/4 cards.
// - Quadrant mode uses limit one/two/three/four for fwd drive/rev regen/rev drive/fwd regen.
// - Terminal mode decodes msb:lsb 00..11 to limits one..four.
// - The terminal-chosen limit applies the same in every quadrant.
// - Analog mode maps 0 to 10 V onto 0 to 200 percent in every quadrant.
// - With enable assigned, a quadrant or terminal mode limit applies only while enable is on, else 200 percent.
// - 200 percent equals 200 percent of the maximum output current.
// - An output with function 10 is on while limiting is being performed.
// - Any of the eight inputs may take function 40, 41 or 42.
// - Select inputs count only in terminal mode; enable gates quadrant and terminal modes.
// - Limiting happens only with control method 3, 4 or 5.
// - Card modes are valid only with that card fitted and take its value.
// - Overload restriction starts at its set current and uses its set decel rate.
module tls_top
    import tls_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] term_in,
    input wire logic [11:0] analog_limit_in,
    input wire tls_motor_t motor_in,
    input wire tls_card_t card1_in,
    input wire tls_card_t card2_in,
    output tls_limit_t limit_out,
    output logic [4:0] out_term,
    output logic irq_out
);
    tls_state_t s;
    tls_state_t n;
    logic [7:0] t_en_asg;
    logic [7:0] t_en_on;
    logic [7:0] t_lsb;
    logic [7:0] t_msb;
    logic en_asg;
    logic en_on;
    logic [1:0] term_idx;
    logic [1:0] quad_idx;
    logic [7:0] ana_pct;
    logic [11:0] cur_code;
    logic method_ok;
    logic capture;
    logic gate;
    logic active;
    logic bad;
    logic [7:0] raw;
    logic [2:0] ev;
    logic [2:0] w1c;
    logic [31:0] rd;

    // Per-terminal function decode
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_term
            tls_term_fn u_fn (
                .func(s.in_func[gi]),
                .pin(term_in[gi]),
                .en_asg(t_en_asg[gi]),
                .en_on(t_en_on[gi]),
                .lsb_on(t_lsb[gi]),
                .msb_on(t_msb[gi])
            );
        end
    endgenerate

    tls_lim_scale u_scale (
        .ana_code(analog_limit_in),
        .pct(s.limit_pct),
        .ana_pct(ana_pct),
        .cur_code(cur_code)
    );

    // Saturate a percent value at full scale
    function automatic logic [7:0] sat_pct(input logic [7:0] v);
        sat_pct = (v > `TLS_PCT_FULL) ? `TLS_PCT_FULL : v;
    endfunction

    // Terminal and method decode
    always_comb begin
        en_asg = |t_en_asg;
        en_on = |t_en_on;
        term_idx = {|t_msb, |t_lsb};
        // fwd drive 1, fwd regen 4, rev drive 3, rev regen 2
        quad_idx = motor_in.reverse ? (motor_in.regen ? 2'd1 : 2'd2)
                                    : (motor_in.regen ? 2'd3 : 2'd0);
        method_ok = (s.method == `TLS_METH_SLV) ||
                    (s.method == `TLS_METH_SLV0) ||
                    (s.method == `TLS_METH_FB);
        gate = en_asg ? en_on : 1'b1;
        capture = hsel & hready & htrans[1];
    end

    // Limit source selection
    always_comb begin
        raw = `TLS_PCT_FULL;
        bad = 1'b0;
        active = 1'b0;
        unique case (s.mode)
            TLS_MODE_QUAD: begin
                raw = s.lim[quad_idx];
                active = gate;
            end
            TLS_MODE_TERM: begin
                raw = s.lim[term_idx];
                active = gate;
            end
            TLS_MODE_ANALOG: begin
                raw = ana_pct;
                active = 1'b1;
            end
            TLS_MODE_CARD1: begin
                raw = sat_pct(card1_in.limit_pct);
                active = card1_in.fitted;
                bad = ~card1_in.fitted;
            end
            TLS_MODE_CARD2: begin
                raw = sat_pct(card2_in.limit_pct);
                active = card2_in.fitted;
                bad = ~card2_in.fitted;
            end
            default: begin
                bad = 1'b1;
            end
        endcase
        active = active & method_ok;
    end

    // Register read mux
    always_comb begin
        rd = 32'h0000_0000;
        unique case (s.a_addr)
            `TLS_OFF_MODE: rd[2:0] = s.mode;
            `TLS_OFF_METHOD: rd[2:0] = s.method;
            `TLS_OFF_LIM1: rd[7:0] = s.lim[0];
            `TLS_OFF_LIM2: rd[7:0] = s.lim[1];
            `TLS_OFF_LIM3: rd[7:0] = s.lim[2];
            `TLS_OFF_LIM4: rd[7:0] = s.lim[3];
            `TLS_OFF_INFN_LO: rd = s.in_func[3:0];
            `TLS_OFF_INFN_HI: rd = s.in_func[7:4];
            `TLS_OFF_OUTFN_LO: rd = s.out_func[3:0];
            `TLS_OFF_OUTFN_HI: rd[7:0] = s.out_func[4];
            `TLS_OFF_OLR: rd = {1'b0, s.olr_decel, s.olr_level,
                                9'h000, s.olr_en};
            `TLS_OFF_STATUS: rd = {9'h000, s.src_bad, s.olr_active,
                                   s.in_limit, s.cur_limit, s.limit_pct};
            `TLS_OFF_IRQ_STAT: rd[2:0] = s.irq_stat;
            `TLS_OFF_IRQ_MASK: rd[2:0] = s.irq_mask;
            default: rd = 32'h0000_0000;
        endcase
    end

    // Next state
    always_comb begin
        n = s;
        w1c = 3'h0;
        // Bus phase tracking, one wait state on reads
        if (s.bus_st == TLS_BUS_RD) begin
            n.bus_st = TLS_BUS_RDOUT;
            n.hrdata = rd;
        end else if (capture) begin
            n.bus_st = hwrite ? TLS_BUS_WR : TLS_BUS_RD;
            n.a_write = hwrite;
            n.a_addr = {haddr[7:2], 2'b00};
        end else begin
            n.bus_st = TLS_BUS_IDLE;
        end
        // Write data phase
        if (s.bus_st == TLS_BUS_WR && s.a_write) begin
            unique case (s.a_addr)
                `TLS_OFF_MODE: n.mode = hwdata[2:0];
                `TLS_OFF_METHOD: n.method = hwdata[2:0];
                `TLS_OFF_LIM1: n.lim[0] = sat_pct(hwdata[7:0]);
                `TLS_OFF_LIM2: n.lim[1] = sat_pct(hwdata[7:0]);
                `TLS_OFF_LIM3: n.lim[2] = sat_pct(hwdata[7:0]);
                `TLS_OFF_LIM4: n.lim[3] = sat_pct(hwdata[7:0]);
                `TLS_OFF_INFN_LO: n.in_func[3:0] = hwdata;
                `TLS_OFF_INFN_HI: n.in_func[7:4] = hwdata;
                `TLS_OFF_OUTFN_LO: n.out_func[3:0] = hwdata;
                `TLS_OFF_OUTFN_HI: n.out_func[4] = hwdata[7:0];
                `TLS_OFF_OLR: begin
                    n.olr_en = hwdata[0];
                    n.olr_level = hwdata[21:10];
                    if (hwdata[21:10] < `TLS_OLR_LVL_MIN) begin
                        n.olr_level = `TLS_OLR_LVL_MIN;
                    end
                    if (hwdata[21:10] > `TLS_OLR_LVL_MAX) begin
                        n.olr_level = `TLS_OLR_LVL_MAX;
                    end
                    n.olr_decel = hwdata[30:22];
                    if (hwdata[30:22] < `TLS_OLR_DEC_MIN) begin
                        n.olr_decel = `TLS_OLR_DEC_MIN;
                    end
                    if (hwdata[30:22] > `TLS_OLR_DEC_MAX) begin
                        n.olr_decel = `TLS_OLR_DEC_MAX;
                    end
                end
                `TLS_OFF_IRQ_STAT: w1c = hwdata[2:0];
                `TLS_OFF_IRQ_MASK: n.irq_mask = hwdata[2:0];
                default: n.mode = s.mode;
            endcase
        end
        // Applied limit, recomputed every cycle
        n.lim_active = active;
        n.limit_pct = active ? raw : `TLS_PCT_FULL;
        n.src_bad = bad;
        n.cur_limit = cur_code;
        n.in_limit = s.lim_active &&
                     (motor_in.demand_pct >= {1'b0, s.limit_pct});
        n.olr_active = s.olr_en &&
                       (motor_in.current >= s.olr_level);
        for (int i = 0; i < 5; i++) begin
            n.out_pins[i] = (s.out_func[i] == `TLS_FN_IN_LIMIT) &
                            s.in_limit;
        end
        // Sticky events, set wins over clear
        ev = 3'h0;
        ev[`TLS_IRQ_LIM_ON] = n.in_limit & ~s.in_limit;
        ev[`TLS_IRQ_LIM_OFF] = ~n.in_limit & s.in_limit;
        ev[`TLS_IRQ_SRC_BAD] = bad & ~s.src_bad;
        n.irq_stat = (s.irq_stat & ~w1c) | ev;
        n.irq = |(n.irq_stat & n.irq_mask);
    end

    // State register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
            s.bus_st <= TLS_BUS_IDLE;
            s.mode <= `TLS_RST_MODE;
            s.method <= `TLS_RST_METHOD;
            s.lim <= {4{`TLS_RST_LIM}};
            s.olr_level <= `TLS_RST_OLR_LEVEL;
            s.olr_decel <= `TLS_RST_OLR_DECEL;
            s.limit_pct <= `TLS_PCT_FULL;
        end else begin
            s <= n;
        end
    end

    // Outputs
    always_comb begin
        hreadyout = (s.bus_st != TLS_BUS_RD);
        hresp = 1'b0;
        hrdata = s.hrdata;
        limit_out.limit_pct = s.limit_pct;
        limit_out.cur_limit = s.cur_limit;
        limit_out.in_limit = s.in_limit;
        limit_out.olr_active = s.olr_active;
        limit_out.olr_decel = s.olr_decel;
        out_term = s.out_pins;
        irq_out = s.irq;
    end

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    sequence rd_addr_s;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence rd_data_s;
        !hreadyout ##1 hreadyout;
    endsequence

    read_wait_a: assert property (rd_addr_s |=> rd_data_s)
        else $error("read data phase not one wait state");
    method_gate_a: assert property (
        !method_ok |=> (limit_out.limit_pct == `TLS_PCT_FULL) ##1
                       !limit_out.in_limit)
        else $error("limit applied with non-vector method");
    quad_map_a: assert property (
        method_ok && gate && s.mode == TLS_MODE_QUAD &&
        motor_in.reverse && motor_in.regen
        |=> limit_out.limit_pct == $past(s.lim[1]))
        else $error("reverse regen did not use limit two");
    quad_fwd_a: assert property (
        method_ok && gate && s.mode == TLS_MODE_QUAD &&
        !motor_in.reverse && !motor_in.regen
        |=> limit_out.limit_pct == $past(s.lim[0]))
        else $error("forward drive did not use limit one");
    term_sel_a: assert property (
        method_ok && gate && s.mode == TLS_MODE_TERM
        |=> limit_out.limit_pct == $past(s.lim[{|t_msb, |t_lsb}]))
        else $error("terminal select picked wrong limit");
    analog_map_a: assert property (
        method_ok && s.mode == TLS_MODE_ANALOG
        |=> limit_out.limit_pct == $past(ana_pct))
        else $error("analog limit not applied");
    enable_off_a: assert property (
        en_asg && !en_on && s.mode <= TLS_MODE_TERM
        |=> limit_out.limit_pct == `TLS_PCT_FULL)
        else $error("limit applied with enable off");
    card_missing_a: assert property (
        (s.mode == TLS_MODE_CARD1 && !card1_in.fitted) ||
        (s.mode == TLS_MODE_CARD2 && !card2_in.fitted)
        |=> limit_out.limit_pct == `TLS_PCT_FULL && s.src_bad)
        else $error("absent card source used");
    // Set must win when a clear lands in the same cycle
    bad_event_a: assert property (
        bad && !s.src_bad |=> s.irq_stat[`TLS_IRQ_SRC_BAD])
        else $error("source fault event lost");
    full_scale_a: assert property (
        limit_out.limit_pct == `TLS_PCT_FULL && $stable(s.limit_pct)
        |=> limit_out.cur_limit == 12'hffe)
        else $error("full percent not full current");
    pct_sat_a: assert property (
        limit_out.limit_pct <= `TLS_PCT_FULL)
        else $error("limit above full scale");
    status_pin_a: assert property (
        s.out_func[0] == `TLS_FN_IN_LIMIT |=>
        out_term[0] == $past(limit_out.in_limit))
        else $error("in-limit output mismatch");
    in_limit_a: assert property (
        s.lim_active && motor_in.demand_pct >= {1'b0, s.limit_pct}
        |=> limit_out.in_limit)
        else $error("limiting not reported");
    hresp_okay_a: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    olr_start_a: assert property (
        s.olr_en && motor_in.current >= s.olr_level
        |=> limit_out.olr_active)
        else $error("overload restriction not started");
    irq_level_a: assert property (
        irq_out == |(s.irq_stat & s.irq_mask))
        else $error("interrupt level mismatch");
endmodule // tls_top

// File: dv/tls_far_model.sv
`timescale 1ns/1ps

// Far side: input terminals, analog source, motor loop and cards
module tls_far_model
    import tls_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic en,
    input wire logic [1:0] sel,
    input wire logic rev,
    input wire logic regen,
    input wire logic [8:0] demand,
    input wire logic [11:0] ana,
    input wire logic c1_fit,
    input wire logic [7:0] c1_pct,
    input wire logic c2_fit,
    input wire logic [7:0] c2_pct,
    output logic [7:0] term_in,
    output logic [11:0] analog_limit_in,
    output tls_motor_t motor_in,
    output tls_card_t card1_in,
    output tls_card_t card2_in
);
    logic [4:0] spare_r;

    // Unassigned terminals keep moving so they are never mistaken for selects
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            spare_r <= 5'h00;
        end else begin
            spare_r <= spare_r + 5'h01;
        end
    end

    // Terminals 1 to 3 carry enable, select LSB and select MSB
    assign term_in = {spare_r, sel[1], sel[0], en};
    assign analog_limit_in = ana;
    // Quadrant and demand; current follows the demand
    assign motor_in = '{reverse: rev, regen: regen, demand_pct: demand,
                        current: {demand, 3'h0}};
    // A card that is not fitted shows junk on its limit lines
    assign card1_in = '{fitted: c1_fit, limit_pct: c1_fit ? c1_pct : ~c1_pct};
    assign card2_in = '{fitted: c2_fit, limit_pct: c2_fit ? c2_pct : ~c2_pct};
endmodule // tls_far_model

// File: dv/testbench.sv
`timescale 1ns/1ps
`include "tls_regs.svh"

module testbench
    import tls_pkg::*;
;
    logic core_clk, nrst, hsel, hwrite, hreadyout, hresp, irq_out;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, sel;
    logic [2:0] hsize;
    logic [4:0] out_term;
    logic [7:0] term_in, c1_pct, c2_pct;
    logic [11:0] analog_limit_in, ana;
    logic en, rev, regen, c1_fit, c2_fit;
    logic [8:0] demand;
    logic [3:0][7:0] lim;
    logic [11:0] corner [4] = '{12'h000, 12'h013, 12'hfa0, 12'hfff};
    tls_motor_t motor_in;
    tls_card_t card1_in, card2_in;
    tls_limit_t limit_out;
    int bad_count, check_count;

    tls_top dut_u (.core_clk(core_clk), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .term_in(term_in),
        .analog_limit_in(analog_limit_in), .motor_in(motor_in),
        .card1_in(card1_in), .card2_in(card2_in), .limit_out(limit_out),
        .out_term(out_term), .irq_out(irq_out));

    tls_far_model far_u (.core_clk(core_clk), .nrst(nrst), .en(en),
        .sel(sel), .rev(rev), .regen(regen), .demand(demand), .ana(ana),
        .c1_fit(c1_fit), .c1_pct(c1_pct), .c2_fit(c2_fit), .c2_pct(c2_pct),
        .term_in(term_in), .analog_limit_in(analog_limit_in),
        .motor_in(motor_in), .card1_in(card1_in), .card2_in(card2_in));

    // Quadrant {reverse, regen} to limit slot
    function automatic int quad_idx(input logic [1:0] q);
        case (q)
            2'b00: return 0;
            2'b11: return 1;
            2'b10: return 2;
            default: return 3;
        endcase
    endfunction

    function automatic logic [11:0] cur_of(input logic [7:0] p);
        return 12'((32'(p) * 32'h0000_51e6) >> 10);
    endfunction

    // Analog code 4000 is full scale; anything above saturates
    function automatic logic [7:0] ana_exp(input logic [11:0] c);
        return (c >= 12'hfa0) ? 8'hc8 : 8'(c / 12'h014);
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // One AHB single transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rdv);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        // Address phase stands until hready is seen high
        do begin
            @(posedge core_clk);
        end while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        // Data phase; only the watchdog ends a hung wait
        do begin
            @(posedge core_clk);
        end while (hreadyout !== 1'b1);
        rdv = hrdata;
        chk(32'(hresp), 32'h0);
    endtask

    task automatic complete_run();
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        complete_run();
    end

    initial begin
        nrst = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        {en, sel, rev, regen, demand, ana} = '0;
        {c1_fit, c2_fit, c1_pct, c2_pct} = '0;
        bad_count = 0;
        check_count = 0;
        void'($urandom(53));
        step(2);
        nrst <= 1'b1;
        step(1);
        // Reset values, saturation on write, unmapped place
        bus(1'b0, `TLS_OFF_MODE, 32'h0, rd);
        chk(rd, 32'h0);
        bus(1'b0, `TLS_OFF_METHOD, 32'h0, rd);
        chk(rd, 32'h3);
        bus(1'b1, `TLS_OFF_LIM1, 32'hff, rd);
        bus(1'b0, `TLS_OFF_LIM1, 32'h0, rd);
        chk(rd, 32'hc8);
        bus(1'b1, 8'h38, 32'hffff_ffff, rd);
        bus(1'b0, 8'h38, 32'h0, rd);
        chk(rd, 32'h0);
        // Terminal functions, in-limit output, overload restriction
        bus(1'b1, `TLS_OFF_INFN_LO, {8'h00, `TLS_FN_SEL_MSB,
            `TLS_FN_SEL_LSB, `TLS_FN_ENABLE}, rd);
        bus(1'b1, `TLS_OFF_OUTFN_LO, 32'(`TLS_FN_IN_LIMIT), rd);
        bus(1'b1, `TLS_OFF_OLR, 32'h4b10_0001, rd);
        bus(1'b0, `TLS_OFF_OLR, 32'h0, rd);
        chk(rd, 32'h4b10_0001);
        chk(32'(limit_out.olr_decel), 32'h12c);
        chk(32'(limit_out.olr_active), 32'h0);
        for (int i = 0; i < 4; i++) begin
            lim[i] = 8'($urandom_range(200, 1));
            bus(1'b1, 8'(`TLS_OFF_LIM1 + 4 * i), 32'(lim[i]), rd);
        end
        // Quadrant mode: selects must be ignored
        en <= 1'b1;
        for (int q = 0; q < 4; q++) begin
            {rev, regen} <= 2'(q);
            sel <= 2'($urandom);
            step(3);
            chk(32'(limit_out.limit_pct), 32'(lim[quad_idx(2'(q))]));
            chk(32'(limit_out.cur_limit),
                32'(cur_of(lim[quad_idx(2'(q))])));
        end
        en <= 1'b0;
        step(3);
        chk(32'(limit_out.limit_pct), 32'hc8);
        chk(32'(limit_out.cur_limit), 32'hffe);
        // Terminal mode: all four codes, random quadrants, checked two cycles after each change
        bus(1'b1, `TLS_OFF_MODE, 32'(TLS_MODE_TERM), rd);
        en <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            sel <= 2'(i);
            {rev, regen} <= 2'($urandom);
            step(2);
            chk(32'(limit_out.limit_pct), 32'(lim[i % 4]));
        end
        // In-limit status and interrupt at the demand boundary
        sel <= 2'h0;
        bus(1'b1, `TLS_OFF_IRQ_MASK, 32'h1, rd);
        bus(1'b1, `TLS_OFF_IRQ_STAT, 32'h7, rd);
        demand <= 9'(lim[0]);
        step(4);
        chk(32'(limit_out.in_limit), 32'h1);
        chk(32'(out_term), 32'h1);
        chk(32'(irq_out), 32'h1);
        bus(1'b1, `TLS_OFF_IRQ_STAT, 32'h1, rd);
        step(3);
        chk(32'(irq_out), 32'h0);
        demand <= 9'(lim[0]) - 9'h001;
        step(4);
        chk(32'(limit_out.in_limit), 32'h0);
        chk(32'(out_term), 32'h0);
        chk(32'(irq_out), 32'h0);
        bus(1'b0, `TLS_OFF_IRQ_STAT, 32'h0, rd);
        chk(32'(rd[1:0]), 32'h2);
        // Enable off in terminal mode restores the full ceiling
        demand <= 9'h0c7;
        en <= 1'b0;
        step(4);
        chk(32'(limit_out.limit_pct), 32'hc8);
        chk(32'(limit_out.in_limit), 32'h0);
        // Control methods: only 3, 4 and 5 limit
        en <= 1'b1;
        demand <= 9'h0c8;
        for (int m = 0; m < 6; m++) begin
            bus(1'b1, `TLS_OFF_METHOD, 32'(m), rd);
            step(4);
            chk(32'(limit_out.in_limit), 32'(m >= 3));
            chk(32'(limit_out.olr_active), 32'h1);
        end
        // Analog mode, enable ignored, corners then random codes
        bus(1'b1, `TLS_OFF_MODE, 32'(TLS_MODE_ANALOG), rd);
        en <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            ana <= (i < 4) ? corner[i] : 12'($urandom);
            {rev, regen} <= 2'($urandom);
            step(2);
            chk(32'(limit_out.limit_pct), 32'(ana_exp(ana)));
        end
        // Expansion cards, then a card pulled and an invalid mode
        c1_fit <= 1'b1;
        c2_fit <= 1'b1;
        c1_pct <= 8'($urandom_range(200));
        c2_pct <= 8'($urandom_range(200));
        bus(1'b1, `TLS_OFF_MODE, 32'(TLS_MODE_CARD1), rd);
        step(3);
        chk(32'(limit_out.limit_pct), 32'(c1_pct));
        bus(1'b1, `TLS_OFF_MODE, 32'(TLS_MODE_CARD2), rd);
        step(3);
        chk(32'(limit_out.limit_pct), 32'(c2_pct));
        c2_fit <= 1'b0;
        step(3);
        chk(32'(limit_out.limit_pct), 32'hc8);
        bus(1'b0, `TLS_OFF_STATUS, 32'h0, rd);
        chk(32'(rd[22]), 32'h1);
        bus(1'b1, `TLS_OFF_MODE, 32'h5, rd);
        step(3);
        chk(32'(limit_out.limit_pct), 32'hc8);
        complete_run();
    end
endmodule // testbench
